//--- hdl/tsp_map.svh
// constants of the timeslot parser
//
// Overview of operation
// RULE_01 - Accept sections only on the configured PID.
// RULE_02 - Consume the 64-bit private section header first.
// RULE_03 - Loop count is entries minus one; each entry opens with an id.
// RULE_04 - Entry holds a 24-bit symbol rate.
// RULE_05 - Entry holds a 24-bit slot duration.
// RULE_06 - Entry holds a 16-bit burst start offset.
// RULE_07 - Inner code bit: zero convolutional, one turbo.
// RULE_08 - Ordering bit: natural or reverse, turbo only.
// RULE_09 - Outer code: 01 RS, 10 CRC, 00 both, 11 neither.
// RULE_10 - Puncturing picks rate; 1001-1110 reserved, 1111 no inner code.
// RULE_11 - Modulation 00001 QPSK, 00000 undefined, rest reserved.
// RULE_12 - Shaping 000 is root raised cosine 0.35.
// RULE_13 - Payload type table; 00, 03, 09 and up reserved.
// RULE_14 - Route and ACM flags: zero means present.
// RULE_15 - SAC length in bytes, without any CRC.
// RULE_16 - Request, M and C, group, logon flags: one means present.
// RULE_17 - Request count is count minus one, ignored without request flag.
// RULE_18 - Turbo with new permutation bit carries four parameters.
// RULE_19 - Preamble length, symbols, then padding to a byte.
// RULE_20 - Preamble symbols are two bits, in-phase first, send order.
// RULE_21 - Stuffing bits are discarded whatever their value.
// RULE_22 - CRC over the whole section leaves zero residue.
// RULE_23 - Failed section keeps the old table and flags an error.
`ifndef TSP_MAP_SVH
`define TSP_MAP_SVH

// apb register offsets
`define TSP_CTRL_OFS     8'h00
`define TSP_STAT_OFS     8'h04
`define TSP_SEL_OFS      8'h08
`define TSP_W0_OFS       8'h10
`define TSP_W1_OFS       8'h14
`define TSP_W2_OFS       8'h18
`define TSP_W3_OFS       8'h1C
`define TSP_W4_OFS       8'h20
`define TSP_W5_OFS       8'h24
`define TSP_W6_OFS       8'h28
`define TSP_W7_OFS       8'h2C
`define TSP_W8_OFS       8'h30
`define TSP_W9_OFS       8'h34
`define TSP_W10_OFS      8'h38

// field positions and reset values
`define TSP_CTRL_EN_BIT  0
`define TSP_CTRL_PID_LSB 16
`define TSP_STAT_VAL_BIT 0
`define TSP_STAT_ERR_BIT 1
`define TSP_STAT_CNT_LSB 8
`define TSP_PID_RST      13'h0000

// section crc
`define TSP_CRC_POLY     32'h04C11DB7
`define TSP_CRC_INIT     32'hFFFFFFFF

// byte positions and counts
`define TSP_LEN_HI_IDX   13'h0001
`define TSP_LEN_LO_IDX   13'h0002
`define TSP_HDR_LAST     13'h0007
`define TSP_FIX_LAST     4'hD
`define TSP_PERM_LAST    4'h6

// field codes
`define TSP_OUT_BOTH     2'h0
`define TSP_OUT_RS       2'h1
`define TSP_OUT_CRC      2'h2
`define TSP_PUN_RSV_LO   4'h9
`define TSP_PUN_RSV_HI   4'hE
`define TSP_PUN_OMIT     4'hF
`define TSP_MOD_UNDEF    5'h00
`define TSP_MOD_QPSK     5'h01
`define TSP_SHAPE_RRC    3'h0
`define TSP_PT_RSV_A     8'h00
`define TSP_PT_RSV_B     8'h03
`define TSP_PT_LAST      8'h08

`endif

//--- hdl/tsp_pkg.sv
// types shared by the timeslot composition parser
package tsp_pkg;

  // one section byte from the demultiplexer
  typedef struct packed {
    logic        valid;
    logic        start;
    logic [12:0] pid;
    logic [7:0]  data;
  } tsp_byte_t;

  // fixed part of one loop entry, first byte in the top bits
  typedef struct packed {
    logic [7:0]  id;
    logic [23:0] sym_rate;
    logic [23:0] dur;
    logic [15:0] offs;
    logic        ict;
    logic        ico;
    logic [1:0]  outer;
    logic [3:0]  punct;
    logic [4:0]  modu;
    logic [2:0]  shape;
    logic [7:0]  ptype;
    logic        route_n;
    logic        acm_n;
    logic [4:0]  sac_len;
    logic        req;
    logic        mc;
    logic        grp;
    logic        logon;
    logic [2:0]  crn;
    logic        newperm;
  } tsp_fix_t;

  // permutation parameters with their reserved lead bits
  typedef struct packed {
    logic [2:0]  r0;
    logic [4:0]  p0;
    logic [5:0]  r1;
    logic [9:0]  p1;
    logic [5:0]  r2;
    logic [9:0]  p2;
    logic [5:0]  r3;
    logic [9:0]  p3;
  } tsp_perm_t;

  // stored entry
  typedef struct packed {
    tsp_fix_t    fix;
    tsp_perm_t   perm;
    logic [7:0]  plen;
    logic [63:0] pre;
  } tsp_entry_t;

  // parser states
  typedef enum logic [7:0] {
    TSP_IDLE = 8'h01,
    TSP_HDR  = 8'h02,
    TSP_LCNT = 8'h04,
    TSP_FIX  = 8'h08,
    TSP_PERM = 8'h10,
    TSP_PLEN = 8'h20,
    TSP_PRE  = 8'h40,
    TSP_TAIL = 8'h80
  } tsp_state_t;

endpackage

//--- hdl/tsp_parser.sv
// timeslot composition section parser with an apb register port
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "tsp_map.svh"

module tsp_parser #(
  parameter int MAX_SLOTS = 16,
  parameter int PRE_BYTES = 8
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  tsp_pkg::tsp_byte_t sec_in,
  output logic               tbl_valid,
  output logic               tbl_update,
  output logic               sec_error
);
  import tsp_pkg::*;

  localparam int IW = (MAX_SLOTS > 1) ? $clog2(MAX_SLOTS) : 1;

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (MAX_SLOTS < 2 || MAX_SLOTS > 256 || (MAX_SLOTS & (MAX_SLOTS - 1)) != 0)
  begin : g_bad_slots
    $error("MAX_SLOTS must be a power of two from 2 to 256");
  end
  if (PRE_BYTES < 1 || PRE_BYTES > 8)
  begin : g_bad_pre
    $error("PRE_BYTES must lie between 1 and 8");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one byte of the section crc, msb first
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      if (r[31] ^ d[i])
        r = {r[30:0], 1'b0} ^ `TSP_CRC_POLY;
      else
        r = {r[30:0], 1'b0};
    end
    return r;
  endfunction

  // keeps the symbols still owed in this byte, clears stuffing
  function automatic logic [7:0] stuff_mask(input logic [8:0] left);
    logic [7:0] m;
    m = 8'h00;
    for (int s = 0; s < 4; s++)
    begin
      if (left > 9'(s))
        m[7 - 2 * s -: 2] = 2'b11;
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tsp_state_t  st_ff;
  tsp_state_t  nxt_st;
  logic [31:0] crc_ff;
  logic [31:0] nxt_crc;
  logic [12:0] bidx_ff;
  logic [12:0] end_ff;
  logic        len_ok_ff;
  logic [3:0]  slen_hi_ff;
  logic [7:0]  lcnt_ff;
  logic [7:0]  ent_ff;
  logic [3:0]  fcnt_ff;
  logic [6:0]  pcnt_ff;
  logic [6:0]  npre_ff;
  logic [111:0] fix_ff;
  logic [55:0] perm_ff;
  logic [7:0]  plen_ff;
  logic [63:0] pre_ff;
  logic        bad_ff;
  logic        wr_ff;
  logic [7:0]  wr_idx_ff;
  logic        act_ff;
  logic [8:0]  cnt_ff;
  logic        valid_ff;
  logic        upd_ff;
  logic        err_ff;
  logic        en_ff;
  logic [12:0] pid_ff;
  logic [7:0]  sel_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  tsp_entry_t  mem_ff [2][MAX_SLOTS];

  logic        take;
  logic        last;
  logic        ent_last;
  logic        pre_last;
  logic        ent_done;
  logic        sec_done;
  logic        good;
  logic        err_evt;
  logic        need_perm;
  logic [8:0]  pre_sum;
  logic [8:0]  pre_left;
  tsp_fix_t    f_nxt;
  logic [7:0]  d;

  // ----------------------------------------------------------------
  // input qualification and section position
  // ----------------------------------------------------------------
  assign take      = sec_in.valid & en_ff & (sec_in.pid == pid_ff); // RULE_01
  assign d         = sec_in.data;
  assign last      = len_ok_ff & (bidx_ff == end_ff) & (st_ff != TSP_IDLE);
  assign ent_last  = (ent_ff == lcnt_ff); // RULE_03
  assign pre_last  = (pcnt_ff == npre_ff - 7'd1);
  assign f_nxt     = tsp_fix_t'({fix_ff[103:0], d});
  assign need_perm = f_nxt.ict & f_nxt.newperm; // RULE_07 RULE_18
  assign pre_sum   = {1'b0, d} + 9'd3;
  assign pre_left  = {1'b0, plen_ff} - {pcnt_ff, 2'b00};
  assign nxt_crc   = crc_byte(sec_in.start ? `TSP_CRC_INIT : crc_ff, d);
  assign sec_done  = take & last & ~sec_in.start;
  // whole section, crc included, must leave a zero residue
  assign good      = sec_done & (st_ff == TSP_TAIL) & ~bad_ff & (nxt_crc == 32'h00000000); // RULE_22
  assign err_evt   = (sec_done & ~good) | (take & sec_in.start & (st_ff != TSP_IDLE));
  assign ent_done  = take & ~sec_in.start & ~last &
                     (((st_ff == TSP_PLEN) & (d == 8'h00)) | ((st_ff == TSP_PRE) & pre_last));

  // ----------------------------------------------------------------
  // parser state machine
  // ----------------------------------------------------------------
  // next state from the current byte
  always_comb
  begin
    nxt_st = st_ff;
    if (take)
    begin
      if (sec_in.start)
        nxt_st = TSP_HDR;
      else if (last)
        nxt_st = TSP_IDLE;
      else
      begin
        case (st_ff)
          TSP_HDR:
            if (bidx_ff == `TSP_HDR_LAST)
              nxt_st = TSP_LCNT; // RULE_02
          TSP_LCNT:
            nxt_st = TSP_FIX;
          TSP_FIX:
            if (fcnt_ff == `TSP_FIX_LAST)
              nxt_st = need_perm ? TSP_PERM : TSP_PLEN; // RULE_18
          TSP_PERM:
            if (fcnt_ff == `TSP_PERM_LAST)
              nxt_st = TSP_PLEN;
          TSP_PLEN:
            if (d == 8'h00)
              nxt_st = ent_last ? TSP_TAIL : TSP_FIX; // RULE_19
            else
              nxt_st = TSP_PRE;
          TSP_PRE:
            if (pre_last)
              nxt_st = ent_last ? TSP_TAIL : TSP_FIX; // RULE_03
          TSP_TAIL:
            nxt_st = TSP_TAIL;
          TSP_IDLE:
            nxt_st = TSP_IDLE;
          default:
            nxt_st = TSP_IDLE;
        endcase
      end
    end
  end

  // state, crc and byte index
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff   <= TSP_IDLE;
      crc_ff  <= `TSP_CRC_INIT;
      bidx_ff <= 13'h0000;
    end
    else if (take)
    begin
      st_ff   <= nxt_st;
      crc_ff  <= nxt_crc;
      bidx_ff <= sec_in.start ? 13'h0001 : bidx_ff + 13'h0001;
    end
  end

  // section length from the header gives the last byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      len_ok_ff  <= 1'b0;
      slen_hi_ff <= 4'h0;
      end_ff     <= 13'h0000;
    end
    else if (take)
    begin
      if (sec_in.start)
        len_ok_ff <= 1'b0;
      else if (st_ff == TSP_HDR && bidx_ff == `TSP_LEN_HI_IDX)
        slen_hi_ff <= d[3:0];
      else if (st_ff == TSP_HDR && bidx_ff == `TSP_LEN_LO_IDX)
      begin
        end_ff    <= {1'b0, slen_hi_ff, d} + 13'h0002;
        len_ok_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // loop entry capture
  // ----------------------------------------------------------------
  // loop count, entry index and byte counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lcnt_ff <= 8'h00;
      ent_ff  <= 8'h00;
      fcnt_ff <= 4'h0;
      pcnt_ff <= 7'h00;
      npre_ff <= 7'h00;
    end
    else if (take && !sec_in.start)
    begin
      case (st_ff)
        TSP_LCNT:
        begin
          lcnt_ff <= d; // RULE_03
          ent_ff  <= 8'h00;
          fcnt_ff <= 4'h0;
        end
        TSP_FIX:
          fcnt_ff <= (fcnt_ff == `TSP_FIX_LAST) ? 4'h0 : fcnt_ff + 4'h1;
        TSP_PERM:
          fcnt_ff <= (fcnt_ff == `TSP_PERM_LAST) ? 4'h0 : fcnt_ff + 4'h1;
        TSP_PLEN:
        begin
          npre_ff <= pre_sum[8:2]; // RULE_19
          pcnt_ff <= 7'h00;
        end
        TSP_PRE:
          pcnt_ff <= pcnt_ff + 7'h01;
        default:
          pcnt_ff <= pcnt_ff;
      endcase
      if (ent_done)
        ent_ff <= ent_ff + 8'h01;
    end
  end

  // fixed fields shift in msb first, permutation only for turbo
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fix_ff  <= '0;
      perm_ff <= '0;
    end
    else if (take && !sec_in.start)
    begin
      if (st_ff == TSP_FIX)
      begin
        fix_ff <= {fix_ff[103:0], d}; // RULE_04 RULE_05 RULE_06
        if (fcnt_ff == `TSP_FIX_LAST && !need_perm)
          perm_ff <= '0; // RULE_18
      end
      else if (st_ff == TSP_PERM)
        perm_ff <= {perm_ff[47:0], d}; // RULE_18
    end
  end

  // preamble symbols kept in send order, stuffing masked to zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      plen_ff <= 8'h00;
      pre_ff  <= '0;
    end
    else if (take && !sec_in.start)
    begin
      if (st_ff == TSP_PLEN)
      begin
        plen_ff <= d;
        pre_ff  <= '0;
      end
      else if (st_ff == TSP_PRE && pcnt_ff < 7'(PRE_BYTES))
        pre_ff[63 - 8 * pcnt_ff -: 8] <= d & stuff_mask(pre_left); // RULE_20 RULE_21
    end
  end

  // entry write pulse and overflow marking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ff     <= 1'b0;
      wr_idx_ff <= 8'h00;
      bad_ff    <= 1'b0;
    end
    else
    begin
      wr_ff <= ent_done && ({1'b0, ent_ff} < 9'(MAX_SLOTS));
      if (ent_done)
        wr_idx_ff <= ent_ff;
      if (take && sec_in.start)
        bad_ff <= 1'b0;
      else if (ent_done && ({1'b0, ent_ff} >= 9'(MAX_SLOTS)))
        bad_ff <= 1'b1;
    end
  end

  // entries go into the bank not in use
  always_ff @(posedge pclk)
  begin
    if (wr_ff)
      mem_ff[~act_ff][wr_idx_ff[IW-1:0]] <= tsp_entry_t'({fix_ff, perm_ff, plen_ff, pre_ff});
  end

  // ----------------------------------------------------------------
  // table commit and error flag
  // ----------------------------------------------------------------
  // a good section swaps banks, a bad one leaves the old table
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act_ff   <= 1'b0;
      cnt_ff   <= 9'h000;
      valid_ff <= 1'b0;
      upd_ff   <= 1'b0;
    end
    else
    begin
      upd_ff <= good;
      if (good)
      begin
        act_ff   <= ~act_ff; // RULE_23
        cnt_ff   <= {1'b0, lcnt_ff} + 9'h001;
        valid_ff <= 1'b1;
      end
    end
  end

  // sticky error, a new event wins over the clearing write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_ff <= 1'b0;
    else if (err_evt)
      err_ff <= 1'b1; // RULE_23
    else if (psel && penable && pready_ff && pwrite && paddr == `TSP_STAT_OFS && pwdata[`TSP_STAT_ERR_BIT])
      err_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic        apb_acc;
  logic        apb_wr;
  logic        hit;
  logic        sel_ok;
  logic [31:0] rd;
  tsp_entry_t  er;
  tsp_fix_t    f;
  tsp_perm_t   p;
  logic [3:0]  req_cnt;
  logic [15:0] dec;

  assign apb_acc = psel & penable & ~pready_ff;
  assign apb_wr  = psel & penable & pready_ff & pwrite;
  assign sel_ok  = valid_ff & ({1'b0, sel_ff} < cnt_ff);
  assign er      = mem_ff[act_ff][sel_ff[IW-1:0]];
  assign f       = er.fix;
  assign p       = er.perm;
  assign req_cnt = f.req ? {1'b0, f.crn} + 4'h1 : 4'h0; // RULE_17

  // decoded view of the coding and sac fields
  always_comb
  begin
    dec     = 16'h0000;
    dec[0]  = (f.outer == `TSP_OUT_RS) | (f.outer == `TSP_OUT_BOTH); // RULE_09
    dec[1]  = (f.outer == `TSP_OUT_CRC) | (f.outer == `TSP_OUT_BOTH); // RULE_09
    dec[2]  = (f.punct == `TSP_PUN_OMIT); // RULE_10
    dec[3]  = (f.punct >= `TSP_PUN_RSV_LO) & (f.punct <= `TSP_PUN_RSV_HI); // RULE_10
    dec[4]  = (f.modu == `TSP_MOD_QPSK); // RULE_11
    dec[5]  = (f.modu == `TSP_MOD_UNDEF); // RULE_11
    dec[6]  = (f.shape == `TSP_SHAPE_RRC); // RULE_12
    dec[7]  = (f.ptype == `TSP_PT_RSV_A) | (f.ptype == `TSP_PT_RSV_B) | (f.ptype > `TSP_PT_LAST); // RULE_13
    dec[8]  = f.ict & f.ico; // RULE_08
    dec[9]  = f.ict & f.newperm; // RULE_18
    dec[10] = ~f.route_n; // RULE_14
    dec[11] = ~f.acm_n; // RULE_14
    dec[12] = f.req; // RULE_16
    dec[13] = f.mc; // RULE_16
    dec[14] = f.grp; // RULE_16
    dec[15] = f.logon; // RULE_16
  end

  // read mux over the register map
  always_comb
  begin
    rd  = 32'h00000000;
    hit = 1'b1;
    case (paddr)
      `TSP_CTRL_OFS: rd = {3'h0, pid_ff, 15'h0000, en_ff};
      `TSP_STAT_OFS: rd = {15'h0000, cnt_ff, 6'h00, err_ff, valid_ff};
      `TSP_SEL_OFS:  rd = {24'h000000, sel_ff};
      `TSP_W0_OFS:   rd = {f.id, f.sym_rate};
      `TSP_W1_OFS:   rd = {8'h00, f.dur};
      `TSP_W2_OFS:   rd = {16'h0000, f.offs};
      `TSP_W3_OFS:   rd = {8'h00, f.ptype, f.shape, f.modu, f.ict, f.ict & f.ico, f.outer, f.punct}; // RULE_08
      `TSP_W4_OFS:   rd = {17'h00000, f.ict & f.newperm, req_cnt == 4'h0 ? 3'h0 : f.crn,
                           f.logon, f.grp, f.mc, f.req, f.sac_len, f.acm_n, f.route_n}; // RULE_15
      `TSP_W5_OFS:   rd = {6'h00, p.p1, 11'h000, p.p0};
      `TSP_W6_OFS:   rd = {6'h00, p.p3, 6'h00, p.p2};
      `TSP_W7_OFS:   rd = {24'h000000, er.plen};
      `TSP_W8_OFS:   rd = er.pre[63:32];
      `TSP_W9_OFS:   rd = er.pre[31:0];
      `TSP_W10_OFS:  rd = {12'h000, req_cnt, dec};
      default:       hit = 1'b0;
    endcase
    if (paddr >= `TSP_W0_OFS && !sel_ok)
      rd = 32'h00000000;
  end

  // one wait state, answer registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff  <= apb_acc;
      prdata_ff  <= (apb_acc && !pwrite) ? rd : 32'h00000000;
      pslverr_ff <= apb_acc & ~hit;
    end
  end

  // control registers written at the completing edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_ff  <= 1'b0;
      pid_ff <= `TSP_PID_RST;
      sel_ff <= 8'h00;
    end
    else if (apb_wr)
    begin
      if (paddr == `TSP_CTRL_OFS)
      begin
        en_ff  <= pwdata[`TSP_CTRL_EN_BIT];
        pid_ff <= pwdata[`TSP_CTRL_PID_LSB +: 13];
      end
      if (paddr == `TSP_SEL_OFS)
        sel_ff <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata     = prdata_ff;
  assign pready     = pready_ff;
  assign pslverr    = pslverr_ff;
  assign tbl_valid  = valid_ff;
  assign tbl_update = upd_ff;
  assign sec_error  = err_ff;

endmodule

//--- testbench/tsp_parser_assertions.sv
// port-level assertions for the timeslot composition parser
`timescale 1ns/10ps
`include "tsp_map.svh"
module tsp_parser_chk (
  input logic               pclk,
  input logic               presetn,
  input logic               psel,
  input logic               penable,
  input logic               pwrite,
  input logic [7:0]         paddr,
  input logic [31:0]        pwdata,
  input logic [31:0]        prdata,
  input logic               pready,
  input logic               pslverr,
  input tsp_pkg::tsp_byte_t sec_in,
  input logic               tbl_valid,
  input logic               tbl_update,
  input logic               sec_error
);
  import tsp_pkg::*;
  // ------------------------------
  // bus timing and table outcome
  // ------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  ready_access_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero");
  unmapped_a: assert property (pready && (paddr == 8'h0C || paddr > 8'h38) |-> pslverr)
    else $error("unmapped access accepted");
  update_byte_a: assert property (tbl_update |-> $past(sec_in.valid) ##1 !tbl_update)
    else $error("update without closing byte");
  no_update_err_a: assert property ($rose(sec_error) |-> !tbl_update)
    else $error("update with error");
  table_keep_a: assert property (tbl_update |-> ##[0:1] tbl_valid ##1 tbl_valid[*4])
    else $error("table valid lost");
  err_sticky_a: assert property (sec_error && !(pready && pwrite && paddr == `TSP_STAT_OFS && pwdata[1])
    |=> sec_error)
    else $error("error flag dropped");
  cover property (tbl_update);
  cover property ($rose(sec_error));
  cover property (pready && pslverr);
endmodule

bind tsp_parser tsp_parser_chk u_chk (.*);

//--- testbench/tsp_demux_model.sv
// demultiplexer model that hands section bytes to the parser
`timescale 1ns/10ps
module tsp_demux_model (
  input  logic               pclk,
  output tsp_pkg::tsp_byte_t sec_in
);
  import tsp_pkg::*;
  initial sec_in = '0;
  // one section byte per valid cycle, random idle gaps show inverted stale data
  task automatic send(input logic [12:0] pid, input logic [7:0] b[$], input int gap);
    for (int i = 0; i < b.size(); i++)
    begin
      sec_in <= '{1'b1, i == 0, pid, b[i]};
      @(posedge pclk);
      repeat ($urandom % (gap + 1))
      begin
        sec_in <= '{1'b0, 1'b0, ~pid, ~b[i]};
        @(posedge pclk);
      end
    end
    sec_in <= '{1'b0, 1'b0, ~pid, 8'h5A};
    @(posedge pclk);
  endtask
endmodule

//--- testbench/tsp_parser_bench.sv
// self-checking bench for the timeslot composition parser
`timescale 1ns/10ps
`include "tsp_map.svh"
module tsp_parser_bench;
  import tsp_pkg::*;
  localparam int          SLOTS = 4;
  localparam logic [12:0] PID_A = 13'h0123; // arbitrary stream number
  localparam logic [7:0]  TID   = 8'hA3;    // arbitrary table number
  logic        pclk = 0, presetn, psel, penable, pwrite, err_d = 0;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, tbl_valid, tbl_update, sec_error;
  tsp_byte_t   sec_in;
  int          errors = 0, check_count = 0;
  logic [32:0] apb_q[$];
  logic        sec_q[$];
  logic [7:0]  sec[$];
  tsp_fix_t    fx[SLOTS+1];
  tsp_perm_t   pm[SLOTS+1];
  logic [7:0]  pl[SLOTS+1];
  logic [63:0] pr[SLOTS+1];
  // ------------------------------
  // clock, design and far side
  // ------------------------------
  always #5 pclk = ~pclk;
  tsp_parser #(.MAX_SLOTS(SLOTS), .PRE_BYTES(8)) dut (.*);
  tsp_demux_model u_dmx (.pclk(pclk), .sec_in(sec_in));
  // ------------------------------
  // compare, report and bus tasks
  // ------------------------------
  task automatic cmp(input string what, input logic [32:0] exp, input logic [32:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one apb transfer, expected {pslverr, prdata} queued first
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    apb_q.push_back(e);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (int n = 0; n < 16; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
      if (n == 15)
      begin
        errors++;
        stop_test;
      end
    end
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(0, a, $urandom, {1'b0, e});
  endtask
  // build a section of n entries with field codes counting from k0
  task automatic make(input int n, input int k0);
    logic [31:0] c;
    logic [11:0] len;
    sec = {TID, 8'hB0, 8'h00, 8'h00, 8'h01, 8'hC1, 8'h00, 8'h00, 8'(n - 1)};
    for (int e = 0; e < n; e++)
    begin
      fx[e] = 112'({$urandom, $urandom, $urandom, $urandom});
      pm[e] = 56'({$urandom, $urandom});
      pr[e] = {$urandom, $urandom};
      pl[e] = 8'($urandom % 33);
      {fx[e].punct, fx[e].outer, fx[e].modu, fx[e].shape, fx[e].ptype} = {4'(k0 + e), 2'(k0 + e),
        5'(k0 + e), 3'(k0 + e), 8'(k0 + e)};
      {fx[e].ict, fx[e].newperm, fx[e].req} = 3'(k0 + e);
      for (int i = 13; i >= 0; i--)
        sec.push_back(fx[e][i*8 +: 8]);
      for (int i = 6; i >= 0 && fx[e].ict && fx[e].newperm; i--)
        sec.push_back(pm[e][i*8 +: 8]);
      sec.push_back(pl[e]);
      for (int i = 0; i < (pl[e] + 3) / 4; i++)
        sec.push_back(pr[e][63 - 8*i -: 8]);
    end
    len = 12'(sec.size() + 1);
    sec[1][3:0] = len[11:8];
    sec[2] = len[7:0];
    c = 32'hFFFFFFFF;
    foreach (sec[i])
      for (int j = 7; j >= 0; j--)
        c = {c[30:0], 1'b0} ^ ((c[31] ^ sec[i][j]) ? 32'h04C11DB7 : 32'h0);
    for (int i = 3; i >= 0; i--)
      sec.push_back(c[i*8 +: 8]);
  endtask
  // read back every stored entry and compare each word
  task automatic chk(input int n);
    for (int e = 0; e < n; e++)
    begin
      tsp_fix_t    f;
      logic        tp;
      logic [63:0] m;
      f = fx[e];
      tp = f.ict & f.newperm;
      m = pr[e] & ~((64'h1 << (64 - 2 * pl[e])) - 64'h1);
      xfer(1, `TSP_SEL_OFS, e, 33'h0);
      rd(`TSP_W0_OFS, {f.id, f.sym_rate});
      rd(`TSP_W1_OFS, {8'h0, f.dur});
      rd(`TSP_W2_OFS, {16'h0, f.offs});
      rd(`TSP_W3_OFS, {8'h0, f.ptype, f.shape, f.modu, f.ict, f.ict & f.ico, f.outer, f.punct});
      rd(`TSP_W4_OFS, {17'h0, tp, f.req ? f.crn : 3'h0, f.logon, f.grp, f.mc, f.req, f.sac_len, f.acm_n,
        f.route_n});
      rd(`TSP_W5_OFS, tp ? {6'h0, pm[e].p1, 11'h0, pm[e].p0} : 32'h0);
      rd(`TSP_W6_OFS, tp ? {6'h0, pm[e].p3, 6'h0, pm[e].p2} : 32'h0);
      rd(`TSP_W7_OFS, {24'h0, pl[e]});
      rd(`TSP_W8_OFS, m[63:32]);
      rd(`TSP_W9_OFS, m[31:0]);
      rd(`TSP_W10_OFS, {12'h0, f.req ? 4'(f.crn) + 4'h1 : 4'h0, f.logon, f.grp, f.mc, f.req, !f.acm_n,
        !f.route_n, tp, f.ict & f.ico, f.ptype inside {8'h0, 8'h3} || f.ptype > 8'h8, f.shape == 3'h0,
        f.modu == 5'h0, f.modu == 5'h1, f.punct inside {[4'h9:4'hE]}, f.punct == 4'hF, !f.outer[0],
        !f.outer[1]});
    end
  endtask
  // ------------------------------
  // watcher of results against queued notes
  // ------------------------------
  always @(posedge pclk)
  begin
    if (psel && penable && pready)
      cmp("apb", apb_q.size() ? apb_q.pop_front() : 33'h1FFFFFFFF, {pslverr, prdata});
    if (tbl_update === 1'b1 || (sec_error === 1'b1 && err_d !== 1'b1))
      cmp("section", sec_q.size() ? sec_q.pop_front() : 1'bx, tbl_update);
    err_d <= sec_error;
  end
  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} <= '0;
    void'($urandom(32'h89363fb1));
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(`TSP_STAT_OFS, 32'h0);
    xfer(0, 8'h3C, 32'h0, 33'h100000000);
    xfer(1, 8'h0C, 32'hFFFFFFFF, 33'h100000000);
    xfer(1, `TSP_CTRL_OFS, {3'h0, PID_A, 15'h0, 1'b1}, 33'h0);
    rd(`TSP_CTRL_OFS, {3'h0, PID_A, 15'h0, 1'b1});
    make(SLOTS, 0);
    u_dmx.send(PID_A ^ 13'h1, sec, 2);
    rd(`TSP_STAT_OFS, 32'h0);
    for (int s = 0; s < 4; s++)
    begin
      make(SLOTS, s * SLOTS);
      sec_q.push_back(1'b1);
      u_dmx.send(PID_A, sec, s);
      repeat (3) @(posedge pclk);
      rd(`TSP_STAT_OFS, {15'h0, 9'(SLOTS), 8'h01});
      chk(SLOTS);
    end
    // corrupted checksum, then an aborted section followed by a good one
    sec[sec.size() - 1] ^= 8'h01;
    sec_q.push_back(1'b0);
    u_dmx.send(PID_A, sec, 1);
    repeat (3) @(posedge pclk);
    rd(`TSP_STAT_OFS, {15'h0, 9'(SLOTS), 8'h03});
    chk(SLOTS);
    xfer(1, `TSP_STAT_OFS, 32'h2, 33'h0);
    sec[sec.size() - 1] ^= 8'h01;
    sec_q.push_back(1'b0);
    u_dmx.send(PID_A, sec[0:9], 0);
    sec_q.push_back(1'b1);
    u_dmx.send(PID_A, sec, 0);
    xfer(1, `TSP_STAT_OFS, 32'h2, 33'h0);
    make(SLOTS + 1, 3);
    sec_q.push_back(1'b0);
    u_dmx.send(PID_A, sec, 0);
    repeat (3) @(posedge pclk);
    rd(`TSP_STAT_OFS, {15'h0, 9'(SLOTS), 8'h03});
    cmp("pending", 33'h0, 33'(apb_q.size() + sec_q.size()));
    stop_test;
  end
endmodule
